// File: hw/rsar_pkg.sv
package rsar_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int NFLAG  = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RANGE    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ALARM    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FRAME    = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h38;
  localparam logic [1:0]        WORD_MASK    = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int RANGE_LSB   = 0;
  localparam int RANGE_W     = 4;
  localparam int REF_OFF_BIT = 6;
  localparam int ACT_SUP_LSB = 14;
  localparam int ACT_IN_LSB  = 10;
  localparam int TRP_LSB     = 4;
  localparam int ANY_BIT     = 0;
  localparam int FRM_SPAN_BIT = 8;
  localparam int FRM_IN_LSB   = 10;
  localparam int INCL_HIGH    = 0;
  localparam int INCL_LOW     = 1;
  localparam int FLAG_LSB     = 0;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h0;

  // ----------------------------------------------------------------------
  // Range codes and span scales
  // ----------------------------------------------------------------------
  localparam logic [RANGE_W-1:0] CODE_BI_3P0    = 4'h0;
  localparam logic [RANGE_W-1:0] CODE_BI_2P5    = 4'h1;
  localparam logic [RANGE_W-1:0] CODE_BI_1P5    = 4'h2;
  localparam logic [RANGE_W-1:0] CODE_BI_1P25   = 4'h3;
  localparam logic [RANGE_W-1:0] CODE_BI_0P625  = 4'h4;
  localparam logic [RANGE_W-1:0] CODE_UNI_3P0   = 4'h8;
  localparam logic [RANGE_W-1:0] CODE_UNI_2P5   = 4'h9;
  localparam logic [RANGE_W-1:0] CODE_UNI_1P5   = 4'ha;
  localparam logic [RANGE_W-1:0] CODE_UNI_1P25  = 4'hb;

  typedef enum logic [2:0] {
    SCALE_3P0,
    SCALE_2P5,
    SCALE_1P5,
    SCALE_1P25,
    SCALE_0P625
  } rsar_scale_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic input_low;
    logic input_high;
  } rsar_limit_t;

  typedef struct packed {
    logic                 span_en;
    logic [RANGE_W-1:0]   span;
    logic                 in_high_en;
    logic                 in_high;
    logic                 in_low_en;
    logic                 in_low;
  } rsar_frame_t;

endpackage

// File: hw/rsar_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module rsar_sticky #(
  parameter int W = 4
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o
);
  import rsar_pkg::*;

  typedef struct packed {
    logic [W-1:0] flag;
  } rsar_sticky_t;

  rsar_sticky_t s;
  rsar_sticky_t next_s;

  // A set arriving with a clear keeps the flag.
  always_comb begin
    next_s      = s;
    next_s.flag = (s.flag & ~clr_i) | set_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag_o = s.flag;

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (set_i != '0) |=> ((flag_o & $past(set_i)) == $past(set_i)))
    else $error("sticky flag lost a set");
endmodule
`default_nettype wire

// File: hw/rsar_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rsar_regs (
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            app_reset_i,
  input  wire rsar_pkg::rsar_limit_t           limit_i,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [rsar_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire logic [rsar_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [rsar_pkg::STRB_W-1:0]     s_axi_wstrb,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output logic      [1:0]                      s_axi_bresp,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire logic [rsar_pkg::ADDR_W-1:0]     s_axi_araddr,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic      [rsar_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic      [1:0]                      s_axi_rresp,
  output logic      [rsar_pkg::RANGE_W-1:0]    range_code_o,
  output logic                                 onchip_reference_off_o,
  output logic                                 span_bipolar_o,
  output rsar_pkg::rsar_scale_t                span_scale_o,
  output logic                                 range_valid_o,
  output rsar_pkg::rsar_frame_t                frame_extra_o,
  output logic                                 irq_o
);
  import rsar_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 aw_full;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_full;
    logic [DATA_W-1:0]    w_data;
    logic [STRB_W-1:0]    w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [DATA_W-1:0]    rdata;
    logic [1:0]           rresp;
    logic [ADDR_W-1:0]    r_addr;
    logic [RANGE_W-1:0]   range;
    logic                 ref_off;
    logic                 span_incl;
    logic [1:0]           in_incl;
    rsar_limit_t          active;
    logic [NFLAG-1:0]     mask;
    logic                 irq;
    logic                 bipolar;
    rsar_scale_t          scale;
    logic                 range_ok;
    rsar_frame_t          frame;
  } rsar_state_t;

  rsar_state_t      s;
  rsar_state_t      next_s;
  logic             wr_fire;
  logic             rd_fire;
  logic             wr_range;
  logic             rd_alarm;
  logic [NFLAG-1:0] trip;
  logic [NFLAG-1:0] trip_clr;
  logic [NFLAG-1:0] irq_stat;
  logic [NFLAG-1:0] irq_set;
  logic [NFLAG-1:0] irq_clr;

  function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = {a[ADDR_W-1:2], 2'h0};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w      = word_of(a);
    mapped = (w == OFS_RANGE) || (w == OFS_ALARM) || (w == OFS_FRAME) ||
             (w == OFS_IRQ_STAT) || (w == OFS_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------
  rsar_sticky #(.W(NFLAG)) u_trip (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (s.active),
    .clr_i      (trip_clr),
    .flag_o     (trip)
  );

  rsar_sticky #(.W(NFLAG)) u_irq (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (irq_set),
    .clr_i      (irq_clr),
    .flag_o     (irq_stat)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s   = s;
    wr_fire  = s.aw_full && s.w_full && !s.bvalid;
    rd_fire  = s_axi_arvalid && s.arready;
    wr_range = wr_fire && (word_of(s.aw_addr) == OFS_RANGE) && s.w_strb[0];
    rd_alarm = rd_fire && (word_of(s_axi_araddr) == OFS_ALARM);
    irq_clr  = '0;
    // A read of the alarm word releases the latched flags except those still active.
    trip_clr = {NFLAG{rd_alarm || app_reset_i}};
    irq_set  = limit_i & ~s.active;

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_range) begin
        next_s.range   = s.w_data[RANGE_LSB +: RANGE_W];
        next_s.ref_off = s.w_data[REF_OFF_BIT];
      end
      if (word_of(s.aw_addr) == OFS_FRAME && s.w_strb[1]) begin
        next_s.span_incl = s.w_data[FRM_SPAN_BIT];
        next_s.in_incl   = s.w_data[FRM_IN_LSB +: 2];
      end
      if (word_of(s.aw_addr) == OFS_IRQ_MASK && s.w_strb[0]) begin
        next_s.mask = s.w_data[FLAG_LSB +: NFLAG];
      end
      if (word_of(s.aw_addr) == OFS_IRQ_STAT && s.w_strb[0]) begin
        irq_clr = s.w_data[FLAG_LSB +: NFLAG];
      end
      // The alarm word and all reserved bits ignore writes.
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready  = !next_s.w_full;

    // Read channel: one read at a time, answered the cycle after it is taken.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    if (rd_fire) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.r_addr  = s_axi_araddr;
      next_s.rresp   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata   = '0;
      case (word_of(s_axi_araddr))
        OFS_RANGE: begin
          next_s.rdata[RANGE_LSB +: RANGE_W] = s.range;
          next_s.rdata[REF_OFF_BIT]          = s.ref_off;
        end
        OFS_ALARM: begin
          next_s.rdata[ACT_SUP_LSB +: 2] = {s.active.supply_low, s.active.supply_high};
          next_s.rdata[ACT_IN_LSB +: 2]  = {s.active.input_low, s.active.input_high};
          next_s.rdata[TRP_LSB +: NFLAG] = trip;
          next_s.rdata[ANY_BIT]          = |trip;
        end
        OFS_FRAME: begin
          next_s.rdata[FRM_SPAN_BIT]    = s.span_incl;
          next_s.rdata[FRM_IN_LSB +: 2] = s.in_incl;
        end
        OFS_IRQ_STAT: begin
          next_s.rdata[FLAG_LSB +: NFLAG] = irq_stat;
        end
        OFS_IRQ_MASK: begin
          next_s.rdata[FLAG_LSB +: NFLAG] = s.mask;
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end

    // Application reset returns controls to defaults but keeps the range.
    if (app_reset_i) begin
      next_s.ref_off   = 1'b0;
      next_s.span_incl = 1'b0;
      next_s.in_incl   = '0;
      next_s.mask      = '0;
      irq_clr          = '1;
    end

    // Comparator levels are sampled every cycle.
    next_s.active = limit_i;
    next_s.irq    = |(irq_stat & next_s.mask);

    // Span decode of the code that will be held.
    next_s.bipolar  = 1'b0;
    next_s.scale    = SCALE_3P0;
    next_s.range_ok = 1'b1;
    case (next_s.range)
      CODE_BI_3P0: begin
        next_s.bipolar = 1'b1;
        next_s.scale   = SCALE_3P0;
      end
      CODE_BI_2P5: begin
        next_s.bipolar = 1'b1;
        next_s.scale   = SCALE_2P5;
      end
      CODE_BI_1P5: begin
        next_s.bipolar = 1'b1;
        next_s.scale   = SCALE_1P5;
      end
      CODE_BI_1P25: begin
        next_s.bipolar = 1'b1;
        next_s.scale   = SCALE_1P25;
      end
      CODE_BI_0P625: begin
        next_s.bipolar = 1'b1;
        next_s.scale   = SCALE_0P625;
      end
      CODE_UNI_3P0: begin
        next_s.scale = SCALE_3P0;
      end
      CODE_UNI_2P5: begin
        next_s.scale = SCALE_2P5;
      end
      CODE_UNI_1P5: begin
        next_s.scale = SCALE_1P5;
      end
      CODE_UNI_1P25: begin
        next_s.scale = SCALE_1P25;
      end
      default: begin
        next_s.range_ok = 1'b0;
      end
    endcase

    // Extra fields for each serial output frame.
    next_s.frame.span_en    = next_s.span_incl;
    next_s.frame.span       = next_s.span_incl ? next_s.range : RANGE_RESET;
    next_s.frame.in_high_en = next_s.in_incl[INCL_HIGH];
    next_s.frame.in_high    = next_s.in_incl[INCL_HIGH] && limit_i.input_high;
    next_s.frame.in_low_en  = next_s.in_incl[INCL_LOW];
    next_s.frame.in_low     = next_s.in_incl[INCL_LOW] && limit_i.input_low;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s         <= '0;
      s.range   <= RANGE_RESET;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
      s.range_ok <= 1'b1;
      s.bipolar <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready          = s.awready;
  assign s_axi_wready           = s.wready;
  assign s_axi_bvalid           = s.bvalid;
  assign s_axi_bresp            = s.bresp;
  assign s_axi_arready          = s.arready;
  assign s_axi_rvalid           = s.rvalid;
  assign s_axi_rdata            = s.rdata;
  assign s_axi_rresp            = s.rresp;
  assign range_code_o           = s.range;
  assign onchip_reference_off_o = s.ref_off;
  assign span_bipolar_o         = s.bipolar;
  assign span_scale_o           = s.scale;
  assign range_valid_o          = s.range_ok;
  assign frame_extra_o          = s.frame;
  assign irq_o                  = s.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  range_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_range |=> range_code_o == $past(s.w_data[RANGE_LSB +: RANGE_W]))
    else $error("range code not taken from write");

  range_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_range |=> $stable(range_code_o))
    else $error("range code moved without a write");

  ref_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_range && !app_reset_i) |=> onchip_reference_off_o == $past(s.w_data[REF_OFF_BIT]))
    else $error("reference control not taken from write");

  span_decode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (range_code_o == CODE_BI_0P625) |-> (span_bipolar_o && span_scale_o == SCALE_0P625))
    else $error("bipolar span decode wrong");

  uni_decode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (range_code_o == CODE_UNI_1P25) |-> (!span_bipolar_o && span_scale_o == SCALE_1P25))
    else $error("unipolar span decode wrong");

  range_rsvd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (s_axi_rvalid && word_of(s.r_addr) == OFS_RANGE) |->
      (s_axi_rdata[DATA_W-1:REF_OFF_BIT+1] == '0 && s_axi_rdata[5:4] == 2'h0))
    else $error("reserved range bits read nonzero");

  alarm_summary_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (s_axi_rvalid && word_of(s.r_addr) == OFS_ALARM) |->
      (s_axi_rdata[ANY_BIT] == |s_axi_rdata[TRP_LSB +: NFLAG] &&
       s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[DATA_W-1:16] == '0))
    else $error("summary flag or reserved alarm bits wrong");

  active_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_alarm |=> s_axi_rdata[ACT_SUP_LSB +: 2] == $past({limit_i.supply_low, limit_i.supply_high}, 2))
    else $error("active supply flags stale");

  trip_latch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (limit_i.input_high && !app_reset_i) ##1 !app_reset_i |=> trip[FLAG_LSB])
    else $error("input high event not latched");

  trip_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_alarm && s.active == '0) |=> trip == '0)
    else $error("alarm read did not release flags");

  frame_span_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    frame_extra_o.span_en |-> frame_extra_o.span == range_code_o)
    else $error("frame span code mismatch");
endmodule
`default_nettype wire

// File: tb/rsar_limit_src.sv
`timescale 1ns/1ps
`default_nettype none
module rsar_limit_src (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [3:0]       want_i,
  output rsar_pkg::rsar_limit_t limit_o
);
  import rsar_pkg::*;
  // Comparator levels settle one edge after a condition is requested.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      limit_o <= '0;
    end else begin
      limit_o <= want_i;
    end
  end
endmodule
`default_nettype wire

// File: tb/range_select_and_alarm_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module range_select_and_alarm_status_regs_tb;
  import rsar_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              app_reset_i = 1'b0;
  logic [3:0]        want = 4'h0;
  rsar_limit_t       limit;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic [3:0]        strb = 4'hf;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [31:0]       s_axi_rdata, d, f;
  logic [3:0]        range_code_o, p, old, lat, istat, m;
  logic              onchip_reference_off_o, span_bipolar_o, range_valid_o, irq_o;
  rsar_scale_t       span_scale_o;
  rsar_frame_t       fe;
  int                err_total = 0;
  int                compares = 0;
  integer            seed = 32'he8dd;

  always #2 core_clk_i = ~core_clk_i;

  rsar_limit_src u_src (.core_clk_i, .rst_n_i, .want_i(want), .limit_o(limit));
  rsar_regs u_dut (.core_clk_i, .rst_n_i, .app_reset_i, .limit_i(limit),
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .range_code_o, .onchip_reference_off_o,
    .span_bipolar_o, .span_scale_o, .range_valid_o, .frame_extra_o(fe), .irq_o);

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("Error at %0t: bus answer missing", $time);
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge core_clk_i);
      if (s_axi_bvalid === 1'b1 && aw_d && w_d) begin
        rs = s_axi_bresp;
        return;
      end
      if (s_axi_awready === 1'b1 && !aw_d) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_d) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    logic ar_d;
    ar_d = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge core_clk_i);
      if (s_axi_rvalid === 1'b1 && ar_d) begin
        dat = s_axi_rdata;
        rs = s_axi_rresp;
        return;
      end
      if (s_axi_arready === 1'b1 && !ar_d) begin
        ar_d = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    hang();
  endtask

  // Decode model: {valid, bipolar, scale}; undefined codes give all zero.
  function automatic logic [4:0] span_exp(input int c);
    if (c <= 4) return {2'b11, 3'(c)};
    if (c >= 8 && c <= 11) return {2'b10, 3'(c - 8)};
    return 5'h00;
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(OFS_RANGE, d, r);
    chk(d, 32'h0);
    rd(OFS_ALARM, d, r);
    chk(d, 32'h0);
    chk(onchip_reference_off_o, 1'b0);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      d = $random(seed);
      d[3:0] = 4'(c);
      wr(OFS_RANGE, d, r);
      chk(r, RESP_OKAY);
      rd(OFS_RANGE | 8'(c % 4), f, r);
      chk(r, RESP_OKAY);
      chk(f, d & 32'h4f);
      repeat (2) @(posedge core_clk_i);
      chk({range_valid_o, span_bipolar_o, span_scale_o}, span_exp(c));
      chk({range_code_o, onchip_reference_off_o}, {d[3:0], d[6]});
    end
    // A range write without the low byte lane must leave the register alone.
    strb = 4'he;
    wr(OFS_RANGE, 32'h0, r);
    strb = 4'hf;
    chk(r, RESP_OKAY);
    rd(OFS_RANGE, d, r);
    chk(d, f);
    $display("test range codes done");
    wr(OFS_ALARM, 32'hffffffff, r);
    chk(r, RESP_OKAY);
    wr(8'h44, 32'h1, r);
    chk(r, RESP_SLVERR);
    rd(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    rd(OFS_ALARM, d, r);
    chk(d, 32'h0);
    $display("test refused done");
    wr(OFS_RANGE, 32'h4b, r);
    app_reset_i <= 1'b1;
    @(posedge core_clk_i);
    app_reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd(OFS_RANGE + 8'h3, d, r);
    chk(d, 32'hb);
    $display("test app reset done");
    old = 4'h0;
    lat = 4'h0;
    istat = 4'h0;
    for (int i = 0; i < 12; i++) begin
      p = 4'($random(seed));
      want <= p;
      repeat (5) @(posedge core_clk_i);
      istat = istat | (p & ~old);
      lat = lat | p;
      old = p;
      rd(OFS_ALARM, d, r);
      chk(d, {16'h0, p[3:2], 2'b00, p[1:0], 2'b00, lat, 3'b000, |lat});
      lat = p;
      m = 4'($random(seed));
      wr(OFS_IRQ_MASK, {28'h0, m}, r);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, |(istat & m));
      rd(OFS_IRQ_STAT, d, r);
      chk(d, {28'h0, istat});
      d = $random(seed);
      wr(OFS_IRQ_STAT, d, r);
      istat = istat & ~d[3:0];
      f = $random(seed);
      wr(OFS_FRAME, f, r);
      repeat (2) @(posedge core_clk_i);
      chk({fe.span_en, fe.span, fe.in_high_en, fe.in_high, fe.in_low_en, fe.in_low},
          {f[8], f[8] ? 4'hb : 4'h0, f[10], f[10] & p[0], f[11], f[11] & p[1]});
    end
    $display("test alarms done");
    want <= 4'h0;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(OFS_RANGE, d, r);
    chk(d, 32'h0);
    chk(range_code_o, 4'h0);
    $display("test power reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
